/* File: rtl/mft_pkg.sv */
// shared constants and types of the multi-function timer control block
package mft_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL_A     = 8'h00;
	localparam logic [7:0] OFS_CTRL_B     = 8'h04;
	localparam logic [7:0] OFS_CMP_ONE    = 8'h08;
	localparam logic [7:0] OFS_CMP_TWO    = 8'h0C;
	localparam logic [7:0] OFS_CAP_ONE    = 8'h10;
	localparam logic [7:0] OFS_COUNT      = 8'h14;
	localparam logic [7:0] OFS_FLAG_CLEAR = 8'h18;
	localparam logic [7:0] OFS_TMR_CLEAR  = 8'h1C;
	// timer_event_flags_enables fields
	localparam int BIT_CAP_TWO_F  = 7;
	localparam int BIT_CAP_ONE_F  = 6;
	localparam int BIT_CAP_IE     = 5;
	localparam int BIT_CMP_TWO_F  = 4;
	localparam int BIT_CMP_ONE_F  = 3;
	localparam int BIT_CMP_IE     = 2;
	localparam int BIT_OVF_F      = 1;
	localparam int BIT_OVF_IE     = 0;
	localparam logic [7:0] CTRL_A_EN_MASK = 8'h25;
	// timer_mode_prescale_edges fields
	localparam int BIT_CFG_OTHER  = 7;
	localparam int BIT_CAP_EDGE   = 6;
	localparam int BIT_EVT_EDGE   = 5;
	localparam int PS_LSB         = 2;
	localparam int PS_MSB         = 4;
	localparam int MODE_LSB       = 0;
	localparam int MODE_MSB       = 1;
	// reset values
	localparam logic [7:0]  CTRL_A_RST = 8'h00;
	localparam logic [7:0]  CTRL_B_RST = 8'h00;
	localparam logic [15:0] WORD_RST   = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [6:0]  PRE_RST    = 7'h00;
	localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_SOFT   = 2'b00,
		MODE_PWM    = 2'b01,
		MODE_CAPCMP = 2'b10,
		MODE_EXT    = 2'b11
	} mft_mode_t;

	// which compare value is active, one-hot
	typedef enum logic [1:0] {
		PH_ONE = 2'b01,
		PH_TWO = 2'b10
	} mft_phase_t;

	typedef struct packed {
		logic        wreq;
		logic [31:0] rdata;
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [15:0] cmp_one;
		logic [15:0] cmp_two;
		logic [15:0] cap_one;
		logic [15:0] cnt;
		logic [6:0]  pre;
		mft_phase_t  phase;
		logic        pwm;
		logic [1:0]  cap_prev;
		logic        evt_prev;
		logic        irq;
	} mft_state_t;
endpackage

/* File: rtl/mft_timer.sv */
// multi-function timer: control registers, pins, counter and interrupt over Avalon-MM
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
module mft_timer (
	input  wire logic        MCLK,            // system clock, 100 MHz
	input  wire logic        RST,             // asynchronous reset, active high
	input  wire logic [7:0]  AVS_ADDRESS,     // byte address
	input  wire logic        AVS_READ,        // read request
	input  wire logic        AVS_WRITE,       // write request
	input  wire logic [31:0] AVS_WRITEDATA,   // write data
	input  wire logic [3:0]  AVS_BYTEENABLE,  // byte lanes
	output logic      [31:0] AVS_READDATA,    // read data
	output logic             AVS_WAITREQUEST, // stall
	input  wire logic        CAPTURE_ONE_PIN, // first capture input
	input  wire logic        CAPTURE_TWO_PIN, // second capture input
	input  wire logic        EVENT_CLOCK_PIN, // external event clock
	output logic             PWM_COMPARE_OUT, // PWM/compare output
	output logic             CONFIG_BIT_OUT,  // spare configuration bit
	output logic             IRQ              // level interrupt
);
	mft_pkg::mft_state_t r;
	mft_pkg::mft_state_t s;

	logic [1:0]  cap_pin;
	logic [1:0]  cap_edge;
	logic [1:0]  cap_evt;
	logic        req;
	logic        take_wr;
	logic        mode_cap;
	logic        mode_ext;
	logic        evt_edge;
	logic        pre_tick;
	logic        tick;
	logic        match_one;
	logic        match_two;
	logic        wrap;
	logic [7:0]  pre_span;
	logic [6:0]  pre_limit;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [2:0]  ps;
	mft_pkg::mft_mode_t mode;

	assign cap_pin  = {CAPTURE_TWO_PIN, CAPTURE_ONE_PIN};
	assign mode     = mft_pkg::mft_mode_t'(r.ctrl_b[mft_pkg::MODE_MSB:mft_pkg::MODE_LSB]);
	assign mode_cap = (mode == mft_pkg::MODE_CAPCMP);
	assign mode_ext = (mode == mft_pkg::MODE_EXT);
	assign ps       = r.ctrl_b[mft_pkg::PS_MSB:mft_pkg::PS_LSB];

	// edge detect on both capture inputs
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cap
			assign cap_edge[gi] = r.ctrl_b[mft_pkg::BIT_CAP_EDGE] ?
				(~r.cap_prev[gi] & cap_pin[gi]) : (r.cap_prev[gi] & ~cap_pin[gi]);
			assign cap_evt[gi]  = cap_edge[gi] & mode_cap;
		end
	endgenerate

	assign evt_edge = r.ctrl_b[mft_pkg::BIT_EVT_EDGE] ?
		(~r.evt_prev & EVENT_CLOCK_PIN) : (r.evt_prev & ~EVENT_CLOCK_PIN);

	// prescaler: divide by 2**ps
	assign pre_span  = 8'(8'h01 << ps);
	assign pre_limit = 7'(pre_span - 8'h01);
	assign pre_tick  = (r.pre == pre_limit);
	assign tick      = mode_ext ? evt_edge : pre_tick;

	assign match_one = tick && (r.cnt == r.cmp_one) && (mode_cap || r.phase == mft_pkg::PH_ONE);
	assign match_two = tick && !mode_cap && (r.phase == mft_pkg::PH_TWO) && (r.cnt == r.cmp_two);
	assign wrap      = tick && (r.cnt == mft_pkg::CNT_MAX);

	// bus handshake: one wait cycle, then the request completes
	assign req     = AVS_READ || AVS_WRITE;
	assign take_wr = AVS_WRITE && !r.wreq;

	generate
		for (gi = 0; gi < 4; gi++) begin : g_be
			assign wmask[gi*8 +: 8] = {8{AVS_BYTEENABLE[gi]}};
		end
	endgenerate
	assign wval = AVS_WRITEDATA & wmask;

	always_comb begin
		logic [7:0]  clr;
		logic [7:0]  set;
		logic [31:0] rd;
		clr = 8'h00;
		set = 8'h00;
		rd  = mft_pkg::RD_ZERO;
		s   = r;

		s.wreq     = !(req && r.wreq);
		s.cap_prev = cap_pin;
		s.evt_prev = EVENT_CLOCK_PIN;
		s.pre      = pre_tick ? mft_pkg::PRE_RST : 7'(r.pre + 7'h01);

		// register read, loaded while the wait cycle is shown
		case (AVS_ADDRESS)
			mft_pkg::OFS_CTRL_A:  rd = {24'h00_0000, r.ctrl_a};
			mft_pkg::OFS_CTRL_B:  rd = {24'h00_0000, r.ctrl_b};
			mft_pkg::OFS_CMP_ONE: rd = {16'h0000, r.cmp_one};
			mft_pkg::OFS_CMP_TWO: rd = {16'h0000, r.cmp_two};
			mft_pkg::OFS_CAP_ONE: rd = {16'h0000, r.cap_one};
			mft_pkg::OFS_COUNT:   rd = {16'h0000, r.cnt};
			default:              rd = mft_pkg::RD_ZERO;
		endcase
		if (AVS_READ && r.wreq) begin
			s.rdata = rd;
		end

		// counter
		if (tick) begin
			if (mode_cap) begin
				s.cnt = 16'(r.cnt + 16'h0001);
				if (match_one) begin
					s.pwm = ~r.pwm;
				end
			end else begin
				case (r.phase)
					mft_pkg::PH_ONE: begin
						if (match_one) begin
							s.cnt   = mft_pkg::WORD_RST;
							s.phase = mft_pkg::PH_TWO;
							if (mode != mft_pkg::MODE_SOFT) begin
								s.pwm = 1'b1;
							end
						end else begin
							s.cnt = 16'(r.cnt + 16'h0001);
						end
					end
					mft_pkg::PH_TWO: begin
						if (match_two) begin
							s.cnt   = mft_pkg::WORD_RST;
							s.phase = mft_pkg::PH_ONE;
							if (mode != mft_pkg::MODE_SOFT) begin
								s.pwm = 1'b0;
							end
						end else begin
							s.cnt = 16'(r.cnt + 16'h0001);
						end
					end
					default: begin
						s.cnt   = mft_pkg::WORD_RST;
						s.phase = mft_pkg::PH_ONE;
					end
				endcase
			end
		end

		// captures: first pin to its own register, second pin into the second value
		if (cap_evt[0]) begin
			s.cap_one = r.cnt;
		end
		if (cap_evt[1]) begin
			s.cmp_two = r.cnt;
		end

		// register writes
		if (take_wr) begin
			case (AVS_ADDRESS)
				mft_pkg::OFS_CTRL_A: begin
					if (AVS_BYTEENABLE[0]) begin
						s.ctrl_a = (r.ctrl_a & ~mft_pkg::CTRL_A_EN_MASK)
							| (wval[7:0] & mft_pkg::CTRL_A_EN_MASK);
					end
				end
				mft_pkg::OFS_CTRL_B: begin
					if (AVS_BYTEENABLE[0]) begin
						s.ctrl_b = wval[7:0];
					end
				end
				mft_pkg::OFS_CMP_ONE: begin
					s.cmp_one = (r.cmp_one & ~wmask[15:0]) | wval[15:0];
				end
				mft_pkg::OFS_CMP_TWO: begin
					if (!cap_evt[1]) begin
						s.cmp_two = (r.cmp_two & ~wmask[15:0]) | wval[15:0];
					end
				end
				mft_pkg::OFS_FLAG_CLEAR: begin
					clr = wval[7:0] & ~mft_pkg::CTRL_A_EN_MASK;
				end
				mft_pkg::OFS_TMR_CLEAR: begin
					s.cnt   = mft_pkg::WORD_RST;
					s.pre   = mft_pkg::PRE_RST;
					s.phase = mft_pkg::PH_ONE;
				end
				default: begin
				end
			endcase
		end

		// sticky flags: a hardware set beats a clear in the same cycle
		set[mft_pkg::BIT_CAP_TWO_F] = cap_evt[1];
		set[mft_pkg::BIT_CAP_ONE_F] = cap_evt[0];
		set[mft_pkg::BIT_CMP_TWO_F] = match_two;
		set[mft_pkg::BIT_CMP_ONE_F] = match_one;
		set[mft_pkg::BIT_OVF_F]     = wrap;
		s.ctrl_a = (s.ctrl_a & ~clr) | set;

		s.irq = (s.ctrl_a[mft_pkg::BIT_CAP_IE]
				&& (s.ctrl_a[mft_pkg::BIT_CAP_ONE_F] || s.ctrl_a[mft_pkg::BIT_CAP_TWO_F]))
			|| (s.ctrl_a[mft_pkg::BIT_CMP_IE]
				&& (s.ctrl_a[mft_pkg::BIT_CMP_ONE_F] || s.ctrl_a[mft_pkg::BIT_CMP_TWO_F]))
			|| (s.ctrl_a[mft_pkg::BIT_OVF_IE] && s.ctrl_a[mft_pkg::BIT_OVF_F]);
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			r.wreq     <= 1'b1;
			r.rdata    <= mft_pkg::RD_ZERO;
			r.ctrl_a   <= mft_pkg::CTRL_A_RST;
			r.ctrl_b   <= mft_pkg::CTRL_B_RST;
			r.cmp_one  <= mft_pkg::WORD_RST;
			r.cmp_two  <= mft_pkg::WORD_RST;
			r.cap_one  <= mft_pkg::WORD_RST;
			r.cnt      <= mft_pkg::WORD_RST;
			r.pre      <= mft_pkg::PRE_RST;
			r.phase    <= mft_pkg::PH_ONE;
			r.pwm      <= 1'b0;
			r.cap_prev <= 2'b00;
			r.evt_prev <= 1'b0;
			r.irq      <= 1'b0;
		end else begin
			r <= s;
		end
	end

	assign AVS_READDATA    = r.rdata;
	assign AVS_WAITREQUEST = r.wreq;
	assign PWM_COMPARE_OUT = r.pwm;
	assign CONFIG_BIT_OUT  = r.ctrl_b[mft_pkg::BIT_CFG_OTHER];
	assign IRQ             = r.irq;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	property p_bus_wait;
		req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("wait cycle not one cycle");

	property p_cap_two;
		cap_evt[1] |=> r.ctrl_a[mft_pkg::BIT_CAP_TWO_F] && (r.cmp_two == $past(r.cnt));
	endproperty
	a_cap_two: assert property (p_cap_two) else $error("second capture not recorded");

	property p_cap_one;
		cap_evt[0] |=> r.ctrl_a[mft_pkg::BIT_CAP_ONE_F] && (r.cap_one == $past(r.cnt));
	endproperty
	a_cap_one: assert property (p_cap_one) else $error("first capture not recorded");

	property p_cap_irq;
		(cap_evt != 2'b00) && r.ctrl_a[mft_pkg::BIT_CAP_IE] && !take_wr |=> IRQ;
	endproperty
	a_cap_irq: assert property (p_cap_irq) else $error("capture interrupt missing");

	property p_cmp_two;
		match_two |=> r.ctrl_a[mft_pkg::BIT_CMP_TWO_F] && r.phase == mft_pkg::PH_ONE;
	endproperty
	a_cmp_two: assert property (p_cmp_two) else $error("second match flag not set");

	property p_cmp_one;
		match_one && r.ctrl_a[mft_pkg::BIT_CMP_IE] && !take_wr
			|=> r.ctrl_a[mft_pkg::BIT_CMP_ONE_F] && IRQ;
	endproperty
	a_cmp_one: assert property (p_cmp_one) else $error("first match flag or irq missing");

	property p_wrap;
		wrap && !take_wr |=> r.ctrl_a[mft_pkg::BIT_OVF_F] && r.cnt == mft_pkg::WORD_RST;
	endproperty
	a_wrap: assert property (p_wrap) else $error("overflow not flagged");

	property p_ovf_quiet;
		!r.ctrl_a[mft_pkg::BIT_OVF_IE] && !r.ctrl_a[mft_pkg::BIT_CMP_IE]
			&& !r.ctrl_a[mft_pkg::BIT_CAP_IE] && !take_wr |=> !IRQ;
	endproperty
	a_ovf_quiet: assert property (p_ovf_quiet) else $error("interrupt while all gated");

	property p_ext_hold;
		mode_ext && !evt_edge && !take_wr |=> $stable(r.cnt);
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("counter moved without event");

	// two quiet cycles keep a timer clear or a mode write out of the divide window
	property p_pre_div;
		!mode_ext && ps == 3'h1 && pre_tick && !take_wr ##1 !take_wr
			|-> !pre_tick ##1 pre_tick;
	endproperty
	a_pre_div: assert property (p_pre_div) else $error("prescale by two wrong");

	property p_pwm_high;
		mode == mft_pkg::MODE_PWM && match_one && !take_wr |=> PWM_COMPARE_OUT;
	endproperty
	a_pwm_high: assert property (p_pwm_high) else $error("pwm did not rise");

	property p_cc_toggle;
		mode_cap && match_one && !take_wr
			|=> PWM_COMPARE_OUT != $past(PWM_COMPARE_OUT) && r.cnt == 16'($past(r.cnt) + 16'h0001);
	endproperty
	a_cc_toggle: assert property (p_cc_toggle) else $error("compare toggle wrong");

	c_capture: cover property (cap_evt[1] ##1 IRQ);
	c_pwm_cycle: cover property (match_one ##[1:200] match_two);
	c_wrap: cover property (wrap);
	c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule // mft_timer

/* File: testbench/mft_pin_model.sv */
// pin-side model: drives the capture and event clock pins of the timer
module mft_pin_model (
	input  wire logic MCLK,    // system clock
	output logic      cap_one, // to first capture input
	output logic      cap_two, // to second capture input
	output logic      evt_clk  // to event clock input
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] pins_r = 3'b000;

	assign {evt_clk, cap_two, cap_one} = pins_r;

	// set one pin (0 capture one, 1 capture two, 2 event clock), then let it settle
	task automatic drive(input int idx, input logic val, input int hold);
		@(posedge MCLK);
		pins_r[idx] <= val;
		repeat (hold) @(posedge MCLK);
	endtask
endmodule // mft_pin_model

/* File: testbench/test_mft_timer.sv */
// self-checking bench of the multi-function timer control block
module test_mft_timer;
	timeunit 1ns;
	timeprecision 1ns;
	logic        MCLK = 1'b0;
	logic        RST = 1'b1;
	logic [7:0]  AVS_ADDRESS = 8'h00;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        CAPTURE_ONE_PIN;
	logic        CAPTURE_TWO_PIN;
	logic        EVENT_CLOCK_PIN;
	logic        PWM_COMPARE_OUT;
	logic        CONFIG_BIT_OUT;
	logic        IRQ;
	logic [31:0] exp_q[$];
	int          miscompares = 0;
	int          checks_done = 0;
	int          seed = 83;
	logic [15:0] rnd;
	logic        pwm_before;
	localparam int PIN_IRQ = 0;
	localparam int PIN_PWM = 1;
	localparam int PIN_CFG = 2;

	mft_timer mft_timer_i (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .CAPTURE_ONE_PIN(CAPTURE_ONE_PIN),
		.CAPTURE_TWO_PIN(CAPTURE_TWO_PIN), .EVENT_CLOCK_PIN(EVENT_CLOCK_PIN),
		.PWM_COMPARE_OUT(PWM_COMPARE_OUT), .CONFIG_BIT_OUT(CONFIG_BIT_OUT), .IRQ(IRQ));
	mft_pin_model mft_pin_model_i (.MCLK(MCLK), .cap_one(CAPTURE_ONE_PIN),
		.cap_two(CAPTURE_TWO_PIN), .evt_clk(EVENT_CLOCK_PIN));

	initial begin
		forever #5 MCLK = ~MCLK;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// sample an output mid-cycle after its update has landed, return on a rising edge
	task automatic pin(input int sel, input logic exp);
		logic seen;
		repeat (2) @(negedge MCLK);
		seen = (sel == PIN_IRQ) ? IRQ : ((sel == PIN_PWM) ? PWM_COMPARE_OUT : CONFIG_BIT_OUT);
		check({31'h0, seen}, {31'h0, exp});
		@(posedge MCLK);
	endtask

	// one bus transfer, held until waitrequest is sampled low
	task automatic bus(input logic is_wr, input logic [7:0] adr, input logic [31:0] dat);
		AVS_ADDRESS   <= adr;
		AVS_WRITE     <= is_wr;
		AVS_READ      <= !is_wr;
		AVS_WRITEDATA <= dat;
		@(posedge MCLK);
		while (AVS_WAITREQUEST !== 1'b0) @(posedge MCLK);
		AVS_WRITE <= 1'b0;
		AVS_READ  <= 1'b0;
		@(posedge MCLK);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		bus(1'b1, adr, dat);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, adr, 32'h0000_0000);
	endtask

	// read data are compared against the oldest noted expectation
	always @(posedge MCLK) begin
		if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
			check(AVS_READDATA, exp_q.pop_front());
		end
	end

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#1_000_000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		pin(PIN_IRQ, 1'b0);
		pin(PIN_PWM, 1'b0);
		rd(mft_pkg::OFS_CTRL_B, 32'h0000_0000);
		rnd = 16'($random(seed)) | 16'h8000;
		wr(mft_pkg::OFS_CMP_ONE, 32'h0000_8000);
		wr(mft_pkg::OFS_CMP_TWO, {16'h0000, rnd});
		rd(mft_pkg::OFS_CMP_TWO, {16'h0000, rnd});
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		wr(mft_pkg::OFS_FLAG_CLEAR, 32'h0000_00FF);
		wr(mft_pkg::OFS_CTRL_A, 32'h0000_00FF);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_0025);
		rd(8'h20, 32'h0000_0000);
		// capture/compare mode, rising capture edges, counter restarted so captures are known
		wr(mft_pkg::OFS_CTRL_B, 32'h0000_0042);
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		mft_pin_model_i.drive(0, 1'b1, 3);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_0065);
		rd(mft_pkg::OFS_CAP_ONE, 32'h0000_0002);
		pin(PIN_IRQ, 1'b1);
		mft_pin_model_i.drive(1, 1'b1, 3);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_00E5);
		rd(mft_pkg::OFS_CMP_TWO, 32'h0000_000E);
		wr(mft_pkg::OFS_CTRL_A, 32'h0000_0000);
		pin(PIN_IRQ, 1'b0);
		wr(mft_pkg::OFS_FLAG_CLEAR, 32'h0000_00FF);
		mft_pin_model_i.drive(1, 1'b0, 3);
		mft_pin_model_i.drive(0, 1'b0, 3);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_0000);
		// one match with the first value while counting on
		wr(mft_pkg::OFS_CMP_ONE, 32'h0000_0014);
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		wr(mft_pkg::OFS_FLAG_CLEAR, 32'h0000_00FF);
		pwm_before = PWM_COMPARE_OUT;
		repeat (40) @(posedge MCLK);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_0008);
		pin(PIN_PWM, ~pwm_before);
		wr(mft_pkg::OFS_CTRL_A, 32'h0000_0004);
		pin(PIN_IRQ, 1'b1);
		// event counting on rising edges, spare bit set
		wr(mft_pkg::OFS_CMP_ONE, 32'h0000_0003);
		wr(mft_pkg::OFS_CTRL_B, 32'h0000_00A3);
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		wr(mft_pkg::OFS_FLAG_CLEAR, 32'h0000_00FF);
		repeat (3) begin
			mft_pin_model_i.drive(2, 1'b1, 2);
			mft_pin_model_i.drive(2, 1'b0, 2);
		end
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_0004);
		mft_pin_model_i.drive(2, 1'b1, 3);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_000C);
		pin(PIN_PWM, 1'b1);
		pin(PIN_CFG, 1'b1);
		// pwm mode: high after the first match, low after the second, high again after the third
		wr(mft_pkg::OFS_CMP_TWO, 32'h0000_0014);
		wr(mft_pkg::OFS_CTRL_B, 32'h0000_0001);
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		wr(mft_pkg::OFS_FLAG_CLEAR, 32'h0000_00FF);
		repeat (20) @(posedge MCLK);
		pin(PIN_PWM, 1'b0);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_001C);
		pin(PIN_PWM, 1'b1);
		// prescale by two: the counter advances every second system clock
		wr(mft_pkg::OFS_CTRL_B, 32'h0000_0046);
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		repeat (9) @(posedge MCLK);
		rd(mft_pkg::OFS_COUNT, 32'h0000_0005);
		// free run to the wrap from all ones to zero
		wr(mft_pkg::OFS_CMP_ONE, 32'h0000_8000);
		wr(mft_pkg::OFS_CTRL_B, 32'h0000_0042);
		wr(mft_pkg::OFS_TMR_CLEAR, 32'h0000_0000);
		wr(mft_pkg::OFS_FLAG_CLEAR, 32'h0000_00FF);
		wr(mft_pkg::OFS_CTRL_A, 32'h0000_0001);
		pin(PIN_IRQ, 1'b0);
		repeat (65600) @(posedge MCLK);
		rd(mft_pkg::OFS_CTRL_A, 32'h0000_000B);
		pin(PIN_IRQ, 1'b1);
		report_and_stop();
	end
endmodule // test_mft_timer
